// ### hdl/aws_pkg.sv
// Shared constants and types for the analog window supervisor.
// Assumes an 8-bit special-function register bus and one machine clock.
package aws_pkg;
   // Register addresses on the special-function bus
   localparam logic [7:0] AWS_ADDR_RESULT = 8'hD9;
   localparam logic [7:0] AWS_ADDR_CTRL = 8'hDC;
   localparam logic [7:0] AWS_ADDR_CHAN = 8'hDD;
   localparam logic [7:0] AWS_ADDR_FLOOR = 8'hDE;
   localparam logic [7:0] AWS_ADDR_CEIL = 8'hDF;

   // Supervisor control register fields and channel width
   localparam int AWS_BIT_OVER = 7;
   localparam int AWS_BIT_UNDER = 6;
   localparam int AWS_BIT_RSVD = 5;
   localparam int AWS_BIT_REQ = 4;
   localparam int AWS_BIT_EN = 3;
   localparam int AWS_SEL_LSB = 0;
   localparam int AWS_SEL_W = 3;
   localparam int AWS_CHAN_W = 2;

   // Reset values
   localparam logic [7:0] AWS_RST_BYTE = 8'h00;
   localparam logic [2:0] AWS_RST_SEL = 3'h0;

   // Interval timing: base period in machine cycles, counter width
   localparam int AWS_BASE_PERIOD = 512;
   localparam int AWS_CNT_W = 16;

   // Conversion sequencer states, Gray along idle -> cpu / supervisor
   typedef enum logic [1:0] {
      AWS_IDLE = 2'b00,
      AWS_CPU_CONV = 2'b01,
      AWS_SUP_CONV = 2'b10
   } aws_state_t;

   // Request towards the converter core
   typedef struct packed {
      logic start;
      logic [1:0] chan;
   } aws_conv_req_t;

   // Result coming back from the converter core
   typedef struct packed {
      logic done;
      logic [7:0] data;
   } aws_conv_res_t;
endpackage

// ### hdl/aws_interval_timer.sv
// Free-running interval timer for the supervisor.
// Assumes enable and select are stable register outputs of the parent.
`timescale 1ns/10ps
module aws_interval_timer #(
   parameter int CNT_W = aws_pkg::AWS_CNT_W
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Timer settings
   input wire logic enable_i,
   input wire logic [aws_pkg::AWS_SEL_W-1:0] sel_i,
   // One-cycle expiry pulse
   output logic tick_o
);
   import aws_pkg::*;

   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic tick_reg, tick_next;

   // Last count of the selected period, 512 * 2**sel - 1
   function automatic logic [CNT_W-1:0] last_count(input logic [AWS_SEL_W-1:0] sel);
      logic [CNT_W:0] per;
      per = (CNT_W+1)'(AWS_BASE_PERIOD) << sel;
      last_count = CNT_W'(per - (CNT_W+1)'(1));
   endfunction

   // Count machine cycles; held clear while disabled so the first tick is a full interval away
   always_comb begin
      cnt_next = cnt_reg + CNT_W'(1);
      tick_next = 1'b0;
      if (!enable_i) begin
         cnt_next = '0;
      end else if (cnt_reg == last_count(sel_i)) begin
         cnt_next = '0;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else if (ce_i) begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick_o = tick_reg;
endmodule

// ### hdl/aws_supervisor.sv
// Analog window supervisor: periodic monitor conversions, limit check, arbitration.
// Assumes the converter core answers each start with one done pulse and that
// the processor bus gives one-cycle read and write strobes.
`timescale 1ns/10ps
// Notes on behaviour
// - After a supervisor conversion, over flag set when ceiling minus result is negative.
// - After a supervisor conversion, under flag set when result minus floor is negative.
// - Comparison flags change by hardware only at end of a supervisor conversion.
// - Result and limits compare as unsigned zero-extended values.
// - Software writes may set or clear both limit flags.
// - No supervisor requests while the detector enable bit is zero.
// - Interval is 512 times two to the select field, 512 to 65536 cycles.
// - A dedicated 16-bit counter advances once per machine cycle.
// - Each interval expiry requests a conversion.
// - Supervisor conversions use the monitor channel register low two bits.
// - After a supervisor conversion the processor channel bits select again.
// - Expiry during a conversion is held until the result register is read.
// - Supervisor result goes into the shared result register and is compared at the same edge.
// - Interrupt when converter interrupt allow is set and either flag is set.
// - Conversion-active flag reads one during supervisor conversions too.
// - Processor request during a conversion is queued until it completes and the result register has been read.
// - Pending flag is one while a processor request waits, cleared on start.
// - Writing zero to the pending flag cancels the queued processor request.
// - A set limit flag blocks all conversions until software clears both.
// - Floor and ceiling registers each hold an 8-bit bound.
// - Conversion-active flag follows hardware only; writes have no effect.
// - No new conversion starts before the result register has been read.
module aws_supervisor (
   // Clock, reset, clock enable
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Special-function register bus
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   output logic [7:0] sfr_rdata_o,
   // Processor converter control inputs
   input wire logic cpu_conv_req_i,
   input wire logic [aws_pkg::AWS_CHAN_W-1:0] conv_chan_sel_i,
   input wire logic converter_irq_allow_i,
   // Converter core
   output aws_pkg::aws_conv_req_t conv_req_o,
   input wire aws_pkg::aws_conv_res_t conv_res_i,
   // Status towards processor
   output logic conversion_active_flag_o,
   output logic irq_o
);
   import aws_pkg::*;

   // Strobe qualified by one address; every register write decode goes through it
   function automatic logic bus_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
      bus_hit = strobe && (addr == target);
   endfunction

   // Sign of a minus b with both zero-extended to nine bits; the ninth bit
   // keeps a large unsigned difference from being read as negative
   function automatic logic diff_neg(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] d;
      d = {1'b0, a} - {1'b0, b};
      diff_neg = d[8];
   endfunction

   // Register file
   // Limit flags, set by the compare at the end of a supervisor conversion or by software
   logic upper_exceed_flag_reg, upper_exceed_flag_next;
   logic low_breach_flag_reg, low_breach_flag_next;
   // Detector enable and interval select
   logic detector_on_reg, detector_on_next;
   logic [AWS_SEL_W-1:0] interval_sel_reg, interval_sel_next;
   // Monitor channel and the two bounds, plain read-write bytes
   logic [7:0] monitor_channel_reg, monitor_channel_next;
   logic [7:0] limit_floor_reg, limit_floor_next;
   logic [7:0] limit_ceiling_reg, limit_ceiling_next;
   // Shared result register and the read data stage
   logic [7:0] conversion_result_reg, conversion_result_next;
   logic [7:0] rdata_reg, rdata_next;

   // Sequencer state
   aws_state_t state_reg, state_next;
   // Remembered requests and the result-unread mark
   logic cpu_pend_reg, cpu_pend_next;
   logic sup_pend_reg, sup_pend_next;
   logic unread_reg, unread_next;
   // Registered outputs towards the converter and the processor
   aws_conv_req_t conv_req_reg, conv_req_next;
   logic busy_reg, busy_next;
   logic irq_reg, irq_next;

   // One-cycle expiry from the interval timer
   logic tick;
   // Decoded bus strobes
   logic wr_ctrl;
   logic wr_chan;
   logic wr_floor;
   logic wr_ceil;
   logic wr_result;
   logic rd_result;
   // Start qualification
   logic blocked;
   logic can_start;

   // Strobe decode; writes to unmapped addresses match nothing and are dropped
   assign wr_ctrl = bus_hit(sfr_wr_i, sfr_addr_i, AWS_ADDR_CTRL);
   assign wr_chan = bus_hit(sfr_wr_i, sfr_addr_i, AWS_ADDR_CHAN);
   assign wr_floor = bus_hit(sfr_wr_i, sfr_addr_i, AWS_ADDR_FLOOR);
   assign wr_ceil = bus_hit(sfr_wr_i, sfr_addr_i, AWS_ADDR_CEIL);
   assign wr_result = bus_hit(sfr_wr_i, sfr_addr_i, AWS_ADDR_RESULT);
   assign rd_result = bus_hit(sfr_rd_i, sfr_addr_i, AWS_ADDR_RESULT);

   // A set limit flag stops every start until both are cleared, so an
   // out-of-range result cannot be overwritten before software has seen it
   assign blocked = upper_exceed_flag_reg || low_breach_flag_reg;
   // The unread gate also holds back a timer request that expired mid-conversion
   assign can_start = !blocked && !unread_reg;

   // Interval timer, held clear while the detector is off
   aws_interval_timer #(
      .CNT_W(AWS_CNT_W)
   ) i_aws_interval_timer (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .enable_i(detector_on_reg),
      .sel_i(interval_sel_reg),
      .tick_o(tick)
   );

   // Plain register writes; the control write also reaches the flags and the
   // pending bit, which the sequencer owns
   always_comb begin
      detector_on_next = detector_on_reg;
      interval_sel_next = interval_sel_reg;
      monitor_channel_next = monitor_channel_reg;
      limit_floor_next = limit_floor_reg;
      limit_ceiling_next = limit_ceiling_reg;
      if (wr_ctrl) begin
         // Bit 5 is not stored; software is expected to keep it zero
         detector_on_next = sfr_wdata_i[AWS_BIT_EN];
         interval_sel_next = sfr_wdata_i[AWS_SEL_LSB +: AWS_SEL_W];
      end else if (wr_chan) begin
         monitor_channel_next = sfr_wdata_i;
      end else if (wr_floor) begin
         limit_floor_next = sfr_wdata_i;
      end else if (wr_ceil) begin
         limit_ceiling_next = sfr_wdata_i;
      end
   end

   // Sequencer: arbitration, result capture and limit comparison
   always_comb begin
      state_next = state_reg;
      cpu_pend_next = cpu_pend_reg;
      sup_pend_next = sup_pend_reg;
      unread_next = unread_reg;
      conversion_result_next = conversion_result_reg;
      upper_exceed_flag_next = upper_exceed_flag_reg;
      low_breach_flag_next = low_breach_flag_reg;
      conv_req_next = '{start: 1'b0, chan: conv_chan_sel_i};
      // Software side effects first so hardware events below win
      if (wr_ctrl) begin
         upper_exceed_flag_next = sfr_wdata_i[AWS_BIT_OVER];
         low_breach_flag_next = sfr_wdata_i[AWS_BIT_UNDER];
         if (!sfr_wdata_i[AWS_BIT_REQ]) begin
            cpu_pend_next = 1'b0;
         end
      end
      // Software may load the result register; that does not mark it unread
      if (wr_result) begin
         conversion_result_next = sfr_wdata_i;
      end
      // Reading the result frees the converter for the next start
      if (rd_result) begin
         unread_next = 1'b0;
      end

      // Expiry is remembered until it can be served
      if (tick && detector_on_reg) begin
         sup_pend_next = 1'b1;
      end
      // A processor pulse wins over a cancel written in the same cycle
      if (cpu_conv_req_i) begin
         cpu_pend_next = 1'b1;
      end

      // The supervisor outranks a queued processor request; both wait until the
      // result has been read and both limit flags are clear
      case (state_reg)
         AWS_IDLE: begin
            if (can_start && sup_pend_reg && detector_on_reg) begin
               sup_pend_next = 1'b0;
               conv_req_next = '{start: 1'b1, chan: monitor_channel_reg[AWS_CHAN_W-1:0]};
               state_next = AWS_SUP_CONV;
            end else if (can_start && (cpu_pend_reg || cpu_conv_req_i)) begin
               cpu_pend_next = 1'b0;
               conv_req_next.start = 1'b1;
               state_next = AWS_CPU_CONV;
            end
         end
         AWS_CPU_CONV: begin
            // Only the result and the unread mark change at the end
            if (conv_res_i.done) begin
               conversion_result_next = conv_res_i.data;
               unread_next = 1'b1;
               state_next = AWS_IDLE;
            end
         end
         AWS_SUP_CONV: begin
            // Channel stays on the monitor input until the conversion is done
            conv_req_next.chan = monitor_channel_reg[AWS_CHAN_W-1:0];
            if (conv_res_i.done) begin
               conversion_result_next = conv_res_i.data;
               unread_next = 1'b1;
               // Compare the fresh result, so the flags match the value stored at this edge
               // Unsigned 9-bit differences, sign bit marks a negative result
               upper_exceed_flag_next = diff_neg(limit_ceiling_reg, conv_res_i.data);
               low_breach_flag_next = diff_neg(conv_res_i.data, limit_floor_reg);
               state_next = AWS_IDLE;
            end
         end
         default: begin
            state_next = AWS_IDLE;
         end
      endcase
      // Disabling drops a remembered expiry; a running conversion still completes
      if (!detector_on_reg) begin
         sup_pend_next = 1'b0;
      end
   end

   // Outputs and read data, all registered; busy and interrupt use next values
   // so that they line up with the registered start pulse and flags
   always_comb begin
      busy_next = (state_next != AWS_IDLE);
      irq_next = converter_irq_allow_i && (upper_exceed_flag_next || low_breach_flag_next);
      // Idle cycles and unmapped addresses read as zero
      rdata_next = 8'h00;
      if (sfr_rd_i) begin
         // Bit 5 is not stored and reads zero
         if (sfr_addr_i == AWS_ADDR_CTRL) begin
            rdata_next = {upper_exceed_flag_reg, low_breach_flag_reg, 1'b0, cpu_pend_reg,
                          detector_on_reg, interval_sel_reg};
         end else if (sfr_addr_i == AWS_ADDR_CHAN) begin
            rdata_next = monitor_channel_reg;
         end else if (sfr_addr_i == AWS_ADDR_FLOOR) begin
            rdata_next = limit_floor_reg;
         end else if (sfr_addr_i == AWS_ADDR_CEIL) begin
            rdata_next = limit_ceiling_reg;
         end else if (sfr_addr_i == AWS_ADDR_RESULT) begin
            rdata_next = conversion_result_reg;
         end
      end
   end

   // One register stage for all state; reset wins over the clock enable,
   // and clock enable low freezes every bit, timer included
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         upper_exceed_flag_reg <= 1'b0;
         low_breach_flag_reg <= 1'b0;
         detector_on_reg <= 1'b0;
         interval_sel_reg <= AWS_RST_SEL;
         monitor_channel_reg <= AWS_RST_BYTE;
         limit_floor_reg <= AWS_RST_BYTE;
         limit_ceiling_reg <= AWS_RST_BYTE;
         conversion_result_reg <= AWS_RST_BYTE;
         rdata_reg <= AWS_RST_BYTE;
         state_reg <= AWS_IDLE;
         cpu_pend_reg <= 1'b0;
         sup_pend_reg <= 1'b0;
         unread_reg <= 1'b0;
         conv_req_reg <= '0;
         busy_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else if (ce_i) begin
         upper_exceed_flag_reg <= upper_exceed_flag_next;
         low_breach_flag_reg <= low_breach_flag_next;
         detector_on_reg <= detector_on_next;
         interval_sel_reg <= interval_sel_next;
         monitor_channel_reg <= monitor_channel_next;
         limit_floor_reg <= limit_floor_next;
         limit_ceiling_reg <= limit_ceiling_next;
         conversion_result_reg <= conversion_result_next;
         rdata_reg <= rdata_next;
         state_reg <= state_next;
         cpu_pend_reg <= cpu_pend_next;
         sup_pend_reg <= sup_pend_next;
         unread_reg <= unread_next;
         conv_req_reg <= conv_req_next;
         busy_reg <= busy_next;
         irq_reg <= irq_next;
      end
   end

   // Every output comes straight from a flip-flop
   assign sfr_rdata_o = rdata_reg;
   assign conv_req_o = conv_req_reg;
   assign conversion_active_flag_o = busy_reg;
   assign irq_o = irq_reg;
endmodule

// ### tb/aws_sup_asserts.sv
// Port checker for the window supervisor.
// Assumes one machine clock and a bind onto aws_supervisor.
`timescale 1ns/10ps
module aws_sup_asserts (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_rdata_o,
   // Converter link and status
   input wire logic converter_irq_allow_i,
   input wire aws_pkg::aws_conv_req_t conv_req_o,
   input wire aws_pkg::aws_conv_res_t conv_res_i,
   input wire logic conversion_active_flag_o,
   input wire logic irq_o
);
   import aws_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Steps of a conversion and of a limit write followed by its read-back
   sequence s_launch;
      conv_req_o.start;
   endsequence
   sequence s_finish;
      conv_res_i.done && conversion_active_flag_o && ce_i;
   endsequence
   sequence s_ceil_wr_rd;
      sfr_wr_i && ce_i && sfr_addr_i == AWS_ADDR_CEIL ##2 sfr_rd_i && ce_i && sfr_addr_i == AWS_ADDR_CEIL;
   endsequence
   // Busy must track launches and completions exactly; interrupt stays low while not allowed
   a_launch_busy: assert property (s_launch |-> $rose(conversion_active_flag_o))
      else $error("busy did not rise with the launch");
   a_busy_cause: assert property ($rose(conversion_active_flag_o) |-> s_launch)
      else $error("busy rose without a launch");
   a_launch_pulse: assert property (s_launch |=> !conv_req_o.start)
      else $error("launch pulse longer than one cycle");
   a_finish_idle: assert property (s_finish |=> !conversion_active_flag_o)
      else $error("busy stayed high after done");
   a_irq_masked: assert property (!converter_irq_allow_i && ce_i |=> !irq_o)
      else $error("interrupt raised while not allowed");
   // Read port is quiet unless a mapped register is read
   a_rdata_idle: assert property (!sfr_rd_i && ce_i |=> sfr_rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (sfr_rd_i && ce_i && sfr_addr_i[7:2] != 6'h37 &&
      sfr_addr_i != AWS_ADDR_RESULT |=> sfr_rdata_o == 8'h00)
      else $error("unmapped read returned data");
   a_bit5_zero: assert property (sfr_rd_i && ce_i && sfr_addr_i == AWS_ADDR_CTRL |=> !sfr_rdata_o[AWS_BIT_RSVD])
      else $error("control bit 5 read as one");
   a_ceil_readback: assert property (s_ceil_wr_rd |=> sfr_rdata_o == $past(sfr_wdata_i, 3))
      else $error("ceiling read-back mismatch");
endmodule
bind aws_supervisor aws_sup_asserts i_aws_sup_asserts (.clk_i, .rst_b_i, .ce_i, .sfr_addr_i, .sfr_wdata_i,
   .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .converter_irq_allow_i, .conv_req_o, .conv_res_i,
   .conversion_active_flag_o, .irq_o);

// ### tb/aws_conv_model.sv
// Behavioural converter core facing the supervisor.
// Assumes one start pulse per conversion; the bench sets the level.
`timescale 1ns/10ps
module aws_conv_model #(
   parameter int CONV_CYC = 80
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Converter link
   input wire aws_pkg::aws_conv_req_t conv_req_i,
   input wire logic [5:0] level_i,
   output aws_pkg::aws_conv_res_t conv_res_o
);
   import aws_pkg::*;
   int cnt;
   logic [7:0] held;
   // Channel lands in the top bits so the bench sees which input was sampled
   always @(posedge clk_i) begin
      conv_res_o.done <= 1'b0;
      conv_res_o.data <= ~held; // Between results the bus drives the inverted held value: never the stale result
      if (!rst_b_i) begin
         cnt <= 0;
         held <= 8'h00;
      end else if (conv_req_i.start) begin
         cnt <= CONV_CYC;
         held <= {conv_req_i.chan, level_i};
      end else if (cnt == 1) begin
         cnt <= 0;
         conv_res_o.done <= 1'b1;
         conv_res_o.data <= held;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// ### tb/aws_supervisor_test.sv
// Self-checking bench for the window supervisor.
// Assumes the converter model and the bound port checker.
`timescale 1ns/10ps
module aws_supervisor_test;
   import aws_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic req = 1'b0;
   logic [1:0] sel = 2'h2;
   logic allow = 1'b0;
   logic ce = 1'b1;
   logic [5:0] lvl = 6'h05;
   logic [7:0] rdata;
   logic busy;
   logic irq;
   aws_conv_req_t creq;
   aws_conv_res_t cres;
   int failures = 0;
   int n_tests = 0;
   always #50 clk_i = ~clk_i;
   aws_supervisor i_aws_supervisor (.clk_i, .rst_b_i, .ce_i(ce), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
      .sfr_wr_i(bus_wr), .sfr_rd_i(bus_rd), .sfr_rdata_o(rdata), .cpu_conv_req_i(req), .conv_chan_sel_i(sel),
      .converter_irq_allow_i(allow), .conv_req_o(creq), .conv_res_i(cres),
      .conversion_active_flag_o(busy), .irq_o(irq));
   aws_conv_model i_aws_conv_model (.clk_i, .rst_b_i, .conv_req_i(creq), .level_i(lvl), .conv_res_o(cres));
   // Inputs always move 10 ns after the rising edge
   task automatic cyc(input int n = 1);
      repeat (n) @(posedge clk_i);
      #10;
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic stuck();
      failures++;
      tally_and_finish();
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bus cycles leave an idle cycle so a strobe never moves twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      bus_wr = 1'b1;
      cyc();
      bus_wr = 1'b0;
      cyc();
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      bus_rd = 1'b1;
      cyc();
      bus_rd = 1'b0;
      chk(rdata, exp);
      cyc();
   endtask
   task automatic pulse_req();
      req = 1'b1;
      cyc();
      req = 1'b0;
   endtask
   // Bounded waits; a launch or completion that must come and does not ends the run
   task automatic wait_start(input int lim, input bit must, output int n);
      for (n = 0; n < lim && creq.start !== 1'b1; n++)
         cyc();
      if (must && n == lim)
         stuck();
   endtask
   task automatic wait_idle();
      int i;
      for (i = 0; i < 200 && busy !== 1'b0; i++)
         cyc();
      if (i == 200)
         stuck();
   endtask
   // Reset values, read-back, unmapped space, software flag writes
   task automatic t_regs();
      rd_chk(AWS_ADDR_CTRL, 8'h00);
      wr(AWS_ADDR_CEIL, 8'hA5);
      rd_chk(AWS_ADDR_CEIL, 8'hA5);
      rd_chk(8'hDB, 8'h00);
      wr(AWS_ADDR_CTRL, 8'hD0);
      rd_chk(AWS_ADDR_CTRL, 8'hC0);
      wr(AWS_ADDR_CTRL, 8'h00);
      rd_chk(AWS_ADDR_CTRL, 8'h00);
      // A write while the clock enable is low must not land
      ce = 1'b0;
      wr(AWS_ADDR_FLOOR, 8'h5A);
      ce = 1'b1;
      rd_chk(AWS_ADDR_FLOOR, 8'h00);
      wr(AWS_ADDR_RESULT, 8'h3C);
      rd_chk(AWS_ADDR_RESULT, 8'h3C);
   endtask
   task automatic t_cpu();
      int n;
      sel = 2'h1;
      pulse_req();
      wait_start(8, 1'b1, n);
      chk({6'h00, creq.chan}, 8'h01);
      chk({7'h00, busy}, 8'h01);
      wait_idle();
      rd_chk(AWS_ADDR_RESULT, {2'h1, lvl});
   endtask
   // One supervised conversion on channel 3; the result is left unread
   task automatic t_sup(input logic [2:0] ti, input logic [7:0] lo, input logic [7:0] hi);
      int n;
      logic [7:0] res;
      logic [7:0] ctl;
      res = {2'h3, lvl};
      ctl = {hi < res, res < lo, 2'h0, 1'b1, ti};
      wr(AWS_ADDR_CTRL, 8'h00);
      wr(AWS_ADDR_FLOOR, lo);
      wr(AWS_ADDR_CEIL, hi);
      wr(AWS_ADDR_CHAN, 8'h03);
      wr(AWS_ADDR_CTRL, {5'h01, ti});
      wait_start(2000, 1'b1, n);
      chk({7'h00, n > (512 << ti) - 8 && n < (512 << ti) + 8}, 8'h01);
      chk({6'h00, creq.chan}, 8'h03);
      chk({7'h00, busy}, 8'h01);
      wait_idle();
      cyc(2);
      chk({6'h00, creq.chan}, {6'h00, sel});
      rd_chk(AWS_ADDR_CTRL, ctl);
      chk({7'h00, irq}, {7'h00, allow & (ctl[7] | ctl[6])});
   endtask
   // Requests held while the result is unread; queued processor request
   task automatic t_hold();
      int n;
      pulse_req();
      rd_chk(AWS_ADDR_CTRL, 8'h18);
      wait_start(700, 1'b0, n);
      chk({7'h00, n == 700}, 8'h01);
      rd_chk(AWS_ADDR_RESULT, 8'hC5);
      wait_start(8, 1'b1, n);
      chk({6'h00, creq.chan}, 8'h03);
      rd_chk(AWS_ADDR_CTRL, 8'h18);
      wait_idle();
      rd_chk(AWS_ADDR_RESULT, 8'hC5);
      wait_start(8, 1'b1, n);
      chk({6'h00, creq.chan}, {6'h00, sel});
      rd_chk(AWS_ADDR_CTRL, 8'h08);
      wr(AWS_ADDR_CTRL, 8'h00);
      wait_idle();
      rd_chk(AWS_ADDR_RESULT, {2'h1, lvl});
   endtask
   // Out-of-range result blocks conversions; cancel and disable
   task automatic t_block();
      int n;
      rd_chk(AWS_ADDR_RESULT, 8'hC5);
      pulse_req();
      wait_start(1200, 1'b0, n);
      chk({7'h00, n == 1200}, 8'h01);
      rd_chk(AWS_ADDR_CTRL, 8'h99);
      wr(AWS_ADDR_CTRL, 8'h89);
      rd_chk(AWS_ADDR_CTRL, 8'h89);
      wr(AWS_ADDR_CTRL, 8'h00);
      chk({7'h00, irq}, 8'h00);
      wait_start(1200, 1'b0, n);
      chk({7'h00, n == 1200}, 8'h01);
   endtask
   // Main sequence
   initial begin
      cyc(2);
      rst_b_i = 1'b1;
      t_regs();
      t_cpu();
      t_sup(3'h0, 8'h0A, 8'hF0);
      t_hold();
      allow = 1'b1;
      t_sup(3'h1, 8'h0A, 8'hC0);
      t_block();
      t_sup(3'h0, 8'hD0, 8'hFF);
      tally_and_finish();
   end
endmodule
